// file: src/bci_top.sv
// Purpose: wand decode, serial link and command parser
// Assumes: apb slave, one clock, synchronous reset
// Notes:   decodes code 39 digits in both directions
//
// Function
// - bar input high means dark, low means light
// - widths measured and decoded here; only characters leave
// - elements shorter than 150 us abort, longer than 70 ms end scan
// - link runs 2400 baud, odd parity, one stop bit, full duplex
// - symbology found from the pattern, no prior selection
// - forward and reverse scans both decode
// - supplements only after a forward main symbol; no supplement decode is built here
// - supplements rejected after reset until enabled; supp_en is only stored and never reaches the decode
// - begin marker F0 04 opens the command gateway
// - end marker F0 00 closes the command gateway
// - string must start with escape, hyphen, lowercase y
// - operand is one or two decimal digits
// - each command is operand then operator letter
// - lowercase operators chain, uppercase operator ends the sequence
// - lowercase and uppercase operators act the same
// - operator F enables exactly the symbologies set in operand
// - all symbologies enabled after reset
// - operator C sets the industrial selection bits
// - C with 0 deselects all, 3 selects full ascii code 39; ind_sel is only stored, nothing decodes full ascii
// - carriage return sent after each decoded label
`timescale 1ns/100ps
`include "bci_defs.svh"
module bci_top
  import bci_pkg::*;
#(
  parameter int MIN_CYC = `BCI_MIN_ELEM_CYC,
  parameter int MAX_CYC = `BCI_MAX_ELEM_CYC,
  parameter int BIT_CYC = `BCI_BIT_CYC,
  parameter int DEPTH   = 16
) (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        bar_in,
  input  wire logic        link_rxd,
  output logic             link_txd
);
  // ----------------------------------------------------------------
  // checks and helpers
  // ----------------------------------------------------------------
  if (BIT_CYC < 8 || MIN_CYC < 1 || MAX_CYC <= MIN_CYC || DEPTH < 4 || DEPTH > 64) begin : g_chk
    $error("bci_top: parameter out of range");
  end
  localparam int WW = $clog2(MAX_CYC + 1) + 4;
  localparam int BW = $clog2(BIT_CYC + 1);
  localparam int DW = $clog2(DEPTH);

  function automatic logic [7:0] c39(input logic [8:0] p);
    unique case (p)
      9'b000110100: c39 = 8'h30;
      9'b100100001: c39 = 8'h31;
      9'b001100001: c39 = 8'h32;
      9'b101100000: c39 = 8'h33;
      9'b000110001: c39 = 8'h34;
      9'b100110000: c39 = 8'h35;
      9'b001110000: c39 = 8'h36;
      9'b000100101: c39 = 8'h37;
      9'b100100100: c39 = 8'h38;
      9'b001100100: c39 = 8'h39;
      9'b010000101: c39 = 8'h2D;
      9'b010010100: c39 = `BCI_STAR;
      default:      c39 = 8'h00;
    endcase
  endfunction : c39

  function automatic logic is_digit(input logic [7:0] b);
    is_digit = (b >= `BCI_DIG0) && (b <= `BCI_DIG9);
  endfunction : is_digit

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] bar_sync;
  logic [1:0] rx_sync;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bar_sync <= 2'h0;
      rx_sync  <= 2'h3;
    end else begin
      bar_sync <= {bar_sync[0], bar_in};
      rx_sync  <= {rx_sync[0], link_rxd};
    end
  end
  logic dark;
  assign dark = bar_sync[1];

  // ----------------------------------------------------------------
  // apb slave and settings
  // ----------------------------------------------------------------
  bci_cfg_type cfg;
  bci_cfg_type pend;
  logic        commit;
  logic        apb_wr;
  logic        hit_cfg;
  logic        hit_stat;
  logic        gate_open;
  logic        rev_seen;
  logic [7:0]  rx_last;
  logic        tx_busy;
  assign hit_cfg  = paddr == `BCI_OFS_CFG;
  assign hit_stat = paddr == `BCI_OFS_STAT;
  assign apb_wr   = psel && penable && pwrite && hit_cfg;
  assign pready   = 1'b1;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cfg <= '{supp_en: 1'b0, ind_sel: `BCI_IND_RST, sym_en: `BCI_SYM_RST};
    end else if (apb_wr) begin
      cfg <= '{supp_en: pwdata[16], ind_sel: pwdata[12:8], sym_en: pwdata[4:0]};
    end else if (commit) begin
      cfg <= pend;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pslverr <= psel && !penable && !(hit_cfg || hit_stat);
      if (psel && !penable && !pwrite && hit_cfg) begin
        prdata <= {15'h0, cfg.supp_en, 3'h0, cfg.ind_sel, 3'h0, cfg.sym_en};
      end else if (psel && !penable && !pwrite && hit_stat) begin
        prdata <= {16'h0, rx_last, 5'h0, rev_seen, gate_open, tx_busy};
      end else if (psel && !penable) begin
        prdata <= 32'h0;
      end
    end
  end

  // ----------------------------------------------------------------
  // serial receiver
  // ----------------------------------------------------------------
  logic [BW-1:0] rx_cnt;
  logic [3:0]    rx_bit;
  logic [9:0]    rx_sr;
  logic          rx_act;
  logic          rx_vld;
  logic [7:0]    rx_byte;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rx_act  <= 1'b0;
      rx_cnt  <= '0;
      rx_bit  <= 4'h0;
      rx_sr   <= 10'h0;
      rx_vld  <= 1'b0;
      rx_byte <= 8'h0;
    end else begin
      rx_vld <= 1'b0;
      if (!rx_act) begin
        if (!rx_sync[1]) begin
          rx_act <= 1'b1;
          rx_cnt <= BW'(BIT_CYC / 2);
          rx_bit <= 4'h0;
        end
      end else if (rx_cnt != '0) begin
        rx_cnt <= rx_cnt - 1'b1;
      end else begin
        rx_cnt <= BW'(BIT_CYC - 1);
        rx_bit <= rx_bit + 4'h1;
        rx_sr  <= {rx_sync[1], rx_sr[9:1]};
        if (rx_bit == 4'h0 && rx_sync[1]) begin
          rx_act <= 1'b0;
        end else if (rx_bit == 4'hA) begin
          rx_act <= 1'b0;
          if (rx_sync[1] && (^rx_sr[9:1])) begin
            rx_vld  <= 1'b1;
            rx_byte <= rx_sr[8:1];
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // command gateway and parser
  // ----------------------------------------------------------------
  bci_pstate_type pst;
  logic           mark_seen;
  logic [1:0]     ndig;
  logic [6:0]     opnd;
  logic [7:0]     lc;
  assign lc = rx_byte | 8'h20;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      gate_open <= 1'b0;
      mark_seen <= 1'b0;
      rx_last   <= 8'h0;
    end else if (rx_vld) begin
      rx_last   <= rx_byte;
      mark_seen <= (rx_byte == `BCI_MARK) && !mark_seen;
      if (mark_seen && rx_byte == `BCI_MARK_BEGIN) begin
        gate_open <= 1'b1;
      end else if (mark_seen && rx_byte == `BCI_MARK_END) begin
        gate_open <= 1'b0;
      end
    end
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pst    <= P_ESC;
      ndig   <= 2'h0;
      opnd   <= 7'h0;
      pend   <= '0;
      commit <= 1'b0;
    end else begin
      commit <= 1'b0;
      if (!gate_open || (rx_vld && mark_seen)) begin
        pst  <= P_ESC;
        pend <= cfg;
      end else if (rx_vld && rx_byte != `BCI_MARK) begin
        unique case (pst)
          P_ESC:  pst <= (rx_byte == `BCI_ESC) ? P_DASH : P_BAD;
          P_DASH: pst <= (rx_byte == `BCI_DASH) ? P_Y : P_BAD;
          P_Y: begin
            pst  <= (rx_byte == `BCI_LOW_Y) ? P_NUM : P_BAD;
            ndig <= 2'h0;
            opnd <= 7'h0;
          end
          P_NUM: begin
            if (is_digit(rx_byte)) begin
              ndig <= ndig + 2'h1;
              opnd <= 7'(opnd * 10 + rx_byte[3:0]);
              if (ndig == 2'h2) pst <= P_BAD;
            end else if (ndig == 2'h0) begin
              pst <= P_BAD;
            end else begin
              ndig <= 2'h0;
              opnd <= 7'h0;
              unique case (lc)
                8'h66: pend.sym_en <= opnd[4:0];
                8'h63: pend.ind_sel <= opnd[4:0];
                8'h75: pend.supp_en <= |(opnd & `BCI_SUPP_MASK);
                8'h68: pend.supp_en <= |(opnd & `BCI_SUPP_HMASK);
                8'h67, 8'h6C, 8'h6A, 8'h6B, 8'h73: ;
                default: pst <= P_BAD;
              endcase
              if (!rx_byte[`BCI_CASE_BIT] && (lc == 8'h66 || lc == 8'h63 || lc == 8'h75
                  || lc == 8'h68 || lc == 8'h67 || lc == 8'h6C || lc == 8'h6A
                  || lc == 8'h6B || lc == 8'h73)) begin
                pst    <= P_DONE;
                commit <= 1'b1;
              end
            end
          end
          P_DONE: pst <= P_DONE;
          P_BAD:  pst <= P_BAD;
          default: pst <= P_BAD;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // element width capture and decode
  // ----------------------------------------------------------------
  logic [WW-1:0] wcnt;
  logic [WW-1:0] wid [9];
  logic [3:0]    eidx;
  logic          scan;
  logic          last_dark;
  logic          dec_go;
  logic [WW+3:0] wsum;
  logic [8:0]    pat;
  logic [7:0]    ch_f;
  logic [7:0]    ch_r;
  logic [7:0]    buf_q [DEPTH];
  logic [DW:0]   nch;
  logic          reversed;
  logic          stars;
  logic          lbl_done;
  always_comb begin
    wsum = '0;
    for (int i = 0; i < 9; i++) wsum = wsum + (WW+4)'(wid[i]);
  end
  for (genvar g = 0; g < 9; g++) begin : g_pat
    assign pat[8-g] = ({wid[g], 3'h0} > wsum);
  end
  assign ch_f = c39(pat);
  assign ch_r = c39({pat[0], pat[1], pat[2], pat[3], pat[4], pat[5], pat[6], pat[7], pat[8]});
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wcnt      <= '0;
      eidx      <= 4'h0;
      scan      <= 1'b0;
      last_dark <= 1'b0;
      dec_go    <= 1'b0;
      for (int i = 0; i < 9; i++) wid[i] <= '0;
    end else begin
      last_dark <= dark;
      dec_go    <= 1'b0;
      if (dark != last_dark) begin
        wcnt <= '0;
        if (!scan && dark) begin
          scan <= 1'b1;
          eidx <= 4'h0;
        end else if (scan && wcnt < WW'(MIN_CYC)) begin
          scan <= 1'b0;
        end else if (scan) begin
          if (eidx < 4'h9) wid[eidx] <= wcnt;
          dec_go <= eidx == 4'h8;
          eidx   <= (eidx == 4'h9) ? 4'h0 : eidx + 4'h1;
        end
      end else if (wcnt >= WW'(MAX_CYC)) begin
        scan <= 1'b0;
      end else begin
        wcnt <= wcnt + 1'b1;
      end
    end
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      nch      <= '0;
      stars    <= 1'b0;
      reversed <= 1'b0;
      rev_seen <= 1'b0;
      lbl_done <= 1'b0;
      for (int i = 0; i < DEPTH; i++) buf_q[i] <= 8'h0;
    end else begin
      lbl_done <= 1'b0;
      if (!scan) begin
        stars <= 1'b0;
        nch   <= '0;
      end else if (dec_go && !cfg.sym_en[0]) begin
        stars <= 1'b0;
      end else if (dec_go && !stars) begin
        stars    <= (ch_f == `BCI_STAR) || (ch_r == `BCI_STAR);
        reversed <= ch_f != `BCI_STAR;
        nch      <= '0;
      end else if (dec_go) begin
        if ((reversed ? ch_r : ch_f) == `BCI_STAR) begin
          lbl_done <= nch != '0;
          rev_seen <= reversed;
          stars    <= 1'b0;
        end else if ((reversed ? ch_r : ch_f) == 8'h00 || nch == (DW+1)'(DEPTH)) begin
          stars <= 1'b0;
        end else begin
          buf_q[nch[DW-1:0]] <= reversed ? ch_r : ch_f;
          nch                <= nch + 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // output sequencer and transmitter
  // ----------------------------------------------------------------
  bci_ostate_type ost;
  logic [DW:0]    onum;
  logic [DW:0]    oidx;
  logic           orev;
  logic [7:0]     txq [DEPTH];
  logic           tx_load;
  logic [7:0]     tx_data;
  logic [10:0]    tx_sr;
  logic [BW-1:0]  tx_cnt;
  logic [3:0]     tx_bit;
  assign tx_load = !tx_busy && ost != O_IDLE;
  assign tx_data = (ost == O_CR) ? `BCI_CR
                 : txq[orev ? DW'(onum - oidx - 1'b1) : oidx[DW-1:0]];
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ost  <= O_IDLE;
      onum <= '0;
      oidx <= '0;
      orev <= 1'b0;
      for (int i = 0; i < DEPTH; i++) txq[i] <= 8'h0;
    end else begin
      unique case (ost)
        O_IDLE: if (lbl_done) begin
          ost  <= O_CHAR;
          onum <= nch;
          oidx <= '0;
          orev <= reversed;
          for (int i = 0; i < DEPTH; i++) txq[i] <= buf_q[i];
        end
        O_CHAR: if (tx_load) begin
          oidx <= oidx + 1'b1;
          if (oidx + 1'b1 == onum) ost <= O_CR;
        end
        O_CR: if (tx_load) ost <= O_IDLE;
      endcase
    end
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tx_busy  <= 1'b0;
      tx_sr    <= 11'h7FF;
      tx_cnt   <= '0;
      tx_bit   <= 4'h0;
      link_txd <= 1'b1;
    end else if (tx_load) begin
      tx_busy  <= 1'b1;
      tx_sr    <= {1'b1, ~^tx_data, tx_data, 1'b0};
      tx_cnt   <= BW'(BIT_CYC - 1);
      tx_bit   <= 4'h0;
      link_txd <= 1'b0;
    end else if (tx_busy) begin
      if (tx_cnt != '0) begin
        tx_cnt <= tx_cnt - 1'b1;
      end else begin
        tx_cnt   <= BW'(BIT_CYC - 1);
        tx_bit   <= tx_bit + 4'h1;
        tx_sr    <= {1'b1, tx_sr[10:1]};
        link_txd <= (tx_bit == 4'hA) ? 1'b1 : tx_sr[1];
        tx_busy  <= tx_bit != 4'hA;
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_cfg_reset;
    @(posedge ref_clk) $past(rst) && !rst |-> cfg.sym_en == `BCI_SYM_RST && !cfg.supp_en;
  endproperty
  a_cfg_reset: assert property (p_cfg_reset) else $error("bad settings after reset");
  property p_supp_reset;
    @(posedge ref_clk) disable iff (rst) !cfg.supp_en && !apb_wr && !commit |=> !cfg.supp_en;
  endproperty
  a_supp_reset: assert property (p_supp_reset) else $error("supplement enabled unasked");
  property p_commit_only;
    @(posedge ref_clk) disable iff (rst) !$past(apb_wr) && cfg != $past(cfg) |-> $past(commit);
  endproperty
  a_commit_only: assert property (p_commit_only) else $error("settings changed early");
  property p_bad_quiet;
    @(posedge ref_clk) disable iff (rst) pst == P_BAD |=> !commit;
  endproperty
  a_bad_quiet: assert property (p_bad_quiet) else $error("discarded string committed");
  property p_gate_open;
    @(posedge ref_clk) disable iff (rst)
      rx_vld && mark_seen && rx_byte == `BCI_MARK_BEGIN |=> gate_open [*2];
  endproperty
  a_gate_open: assert property (p_gate_open) else $error("gateway not opened");
  property p_gate_close;
    @(posedge ref_clk) disable iff (rst)
      rx_vld && mark_seen && rx_byte == `BCI_MARK_END |=> !gate_open ##1 pst == P_ESC;
  endproperty
  a_gate_close: assert property (p_gate_close) else $error("gateway not closed");
  property p_tx_frame;
    @(posedge ref_clk) disable iff (rst)
      tx_load |=> !link_txd && (^tx_sr[9:1]) && tx_busy;
  endproperty
  a_tx_frame: assert property (p_tx_frame) else $error("bad start bit or parity");
  property p_cr_last;
    @(posedge ref_clk) disable iff (rst) ost == O_CR && tx_load |=> tx_sr[8:1] == `BCI_CR;
  endproperty
  a_cr_last: assert property (p_cr_last) else $error("missing carriage return");
  property p_short_abort;
    @(posedge ref_clk) disable iff (rst)
      scan && dark != last_dark && wcnt < WW'(MIN_CYC) |=> !scan;
  endproperty
  a_short_abort: assert property (p_short_abort) else $error("short element kept");
  c_commit:  cover property (@(posedge ref_clk) commit);
  c_label:   cover property (@(posedge ref_clk) lbl_done && reversed);
  c_discard: cover property (@(posedge ref_clk) pst == P_BAD && gate_open);
endmodule : bci_top

// file: inc/bci_defs.svh
// Purpose: constants of the bar code command interpreter
// Assumes: 25 MHz reference clock
// Notes:   definitions only
`ifndef BCI_DEFS_SVH
`define BCI_DEFS_SVH
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define BCI_CLK_HZ      25000000
`define BCI_BAUD        2400
`define BCI_MIN_ELEM_US 150
`define BCI_MAX_ELEM_MS 70
`define BCI_MIN_ELEM_CYC ((`BCI_MIN_ELEM_US * (`BCI_CLK_HZ / 1000) + 999) / 1000)
`define BCI_MAX_ELEM_CYC (`BCI_MAX_ELEM_MS * (`BCI_CLK_HZ / 1000))
`define BCI_BIT_CYC     (`BCI_CLK_HZ / `BCI_BAUD)
// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define BCI_OFS_CFG     12'h000
`define BCI_OFS_STAT    12'h004
`define BCI_SYM_RST     5'h1F
`define BCI_IND_RST     5'h1D
// ----------------------------------------------------------------
// link bytes
// ----------------------------------------------------------------
`define BCI_MARK        8'hF0
`define BCI_MARK_BEGIN  8'h04
`define BCI_MARK_END    8'h00
`define BCI_ESC         8'h1B
`define BCI_DASH        8'h2D
`define BCI_LOW_Y       8'h79
`define BCI_CR          8'h0D
`define BCI_STAR        8'h2A
`define BCI_DIG0        8'h30
`define BCI_DIG9        8'h39
`define BCI_CASE_BIT    5
`define BCI_SUPP_MASK   7'h0C
`define BCI_SUPP_HMASK  7'h18
`endif

// file: inc/bci_pkg.sv
// Purpose: types of the bar code command interpreter
// Assumes: nothing
// Notes:   constants stand in bci_defs.svh
package bci_pkg;
  typedef struct packed {
    logic       supp_en;
    logic [4:0] ind_sel;
    logic [4:0] sym_en;
  } bci_cfg_type;

  typedef enum logic [5:0] {
    P_ESC  = 6'h01,
    P_DASH = 6'h02,
    P_Y    = 6'h04,
    P_NUM  = 6'h08,
    P_DONE = 6'h10,
    P_BAD  = 6'h20
  } bci_pstate_type;

  typedef enum logic [2:0] {
    O_IDLE = 3'h1,
    O_CHAR = 3'h2,
    O_CR   = 3'h4
  } bci_ostate_type;
endpackage : bci_pkg

// file: dv/bci_kbd_model.sv
// Purpose: keyboard micro side of the serial link
// Assumes: bench clock, line idles high
// Notes:   frames of start, 8 data lsb first, odd parity, stop
`timescale 1ns/100ps
`include "bci_defs.svh"
module bci_kbd_model
#(
  parameter int BIT_CYC = 16
) (
  input  wire logic ref_clk,
  input  wire logic link_txd,
  output logic      link_rxd
);
  logic [7:0]  rx_q [$];
  int          bad_frames = 0;
  logic [10:0] fr;
  initial link_rxd = 1'b1;
  // ----------------------------------------------------------------
  // transmit
  // ----------------------------------------------------------------
  // odd parity frame
  task automatic send_byte(input logic [7:0] b);
    logic [10:0] f;
    f = {1'b1, ~^b, b, 1'b0};
    @(posedge ref_clk);
    for (int i = 0; i < 11; i++) begin
      link_rxd <= f[i];
      repeat (BIT_CYC) @(posedge ref_clk);
    end
  endtask : send_byte
  task automatic send_cmd(input logic gate, input logic pre, input string s);
    if (gate) begin
      send_byte(`BCI_MARK);
      send_byte(`BCI_MARK_BEGIN);
    end
    if (pre) begin
      send_byte(`BCI_ESC);
      send_byte(`BCI_DASH);
      send_byte(`BCI_LOW_Y);
    end
    for (int i = 0; i < s.len(); i++) begin
      send_byte(s[i]);
    end
    if (gate) begin
      send_byte(`BCI_MARK);
      send_byte(`BCI_MARK_END);
    end
  endtask : send_cmd
  // ----------------------------------------------------------------
  // receive
  // ----------------------------------------------------------------
  // mid bit sampling, frame check
  always begin
    @(negedge link_txd);
    repeat (BIT_CYC / 2) @(posedge ref_clk);
    for (int i = 0; i < 11; i++) begin
      fr[i] = link_txd;
      if (i < 10) repeat (BIT_CYC) @(posedge ref_clk);
    end
    if (fr[0] == 1'b0 && fr[10] == 1'b1 && ^fr[9:1] == 1'b1) rx_q.push_back(fr[8:1]);
    else bad_frames++;
  end
endmodule : bci_kbd_model

// file: dv/bci_top_test.sv
// Purpose: self-checking bench of the bar code command interpreter
// Assumes: shortened counts, apb master, keyboard model on the link
// Notes:   code 39 label 1 scanned both ways, command table
`timescale 1ns/100ps
`include "bci_defs.svh"
module bci_top_test;
  logic        ref_clk     = 1'b0;
  logic        rst         = 1'b1;
  logic        psel        = 1'b0;
  logic        penable     = 1'b0;
  logic        pwrite      = 1'b0;
  logic [11:0] paddr       = 12'h000;
  logic [31:0] pwdata      = 32'h00000000;
  logic        bar_in      = 1'b0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        link_rxd;
  logic        link_txd;
  logic [31:0] rd;
  logic        er;
  int          fail_count  = 0;
  int          comparisons = 0;
  int          cyc         = 0;
  string       cs [6]      = '{"3c1F9f", "7x1F", "123F", "0F", "0F", "4u0c0F"};
  logic [1:0]  cf [6]      = '{2'h3, 2'h3, 2'h3, 2'h2, 2'h1, 2'h3};
  logic [31:0] ce [6]      = '{32'h00000301, 32'h00000301, 32'h00000301,
                               32'h00000301, 32'h00000301, 32'h00010000};
  always #20 ref_clk = ~ref_clk;
  // ----------------------------------------------------------------
  // design and keyboard model
  // ----------------------------------------------------------------
  bci_top #(.MIN_CYC(4), .MAX_CYC(200), .BIT_CYC(16)) DUT (
    .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bar_in(bar_in), .link_rxd(link_rxd), .link_txd(link_txd));
  bci_kbd_model #(.BIT_CYC(16)) kbd (
    .ref_clk(ref_clk), .link_txd(link_txd), .link_rxd(link_rxd));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic results();
    if (fail_count == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : results
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      fail_count++;
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge ref_clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // dark bars first, narrow nw wide 24
  task automatic label(input logic rev, input int n, input int nw);
    int         w [$];
    logic [8:0] pat [3] = '{9'h052, 9'h109, 9'h052};
    for (int c = 0; c < 3; c++) begin
      for (int i = 0; i < 9; i++) w.push_back(pat[c][i] ? 24 : nw);
      if (c < 2) w.push_back(nw);
    end
    for (int i = 0; i < 29; i++) begin
      bar_in <= ~i[0];
      repeat (w[rev ? 28 - i : i]) @(posedge ref_clk);
    end
    bar_in <= 1'b0;
    repeat (300) @(posedge ref_clk);
    for (int k = 0; k < 2000 && kbd.rx_q.size() < 2; k++) @(posedge ref_clk);
    chk("label bytes", 32'(n), 32'(kbd.rx_q.size()));
    if (n == 2 && kbd.rx_q.size() == 2) begin
      chk("label char", 32'h00000031, {24'h000000, kbd.rx_q.pop_front()});
      chk("label end", {24'h000000, `BCI_CR}, {24'h000000, kbd.rx_q.pop_front()});
    end
  endtask : label
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      fail_count++;
      results();
    end
  end
  initial begin
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (300) @(posedge ref_clk);
    apb(1'b0, `BCI_OFS_CFG, 32'h00000000, rd, er);
    chk("cfg reset", 32'h00001D1F, rd);
    apb(1'b0, 12'h008, 32'h00000000, rd, er);
    chk("unmapped error", 32'h00000001, {31'h00000000, er});
    apb(1'b1, `BCI_OFS_CFG, 32'h00010A15, rd, er);
    apb(1'b0, `BCI_OFS_CFG, 32'h00000000, rd, er);
    chk("cfg write", 32'h00010A15, rd);
    apb(1'b1, `BCI_OFS_CFG, 32'h00001D1F, rd, er);
    label(1'b0, 2, 8);
    label(1'b1, 2, 8);
    label(1'b0, 0, 3);
    for (int i = 0; i < 6; i++) begin
      kbd.send_cmd(cf[i][1], cf[i][0], cs[i]);
      apb(1'b0, `BCI_OFS_CFG, 32'h00000000, rd, er);
      chk(cs[i], ce[i], rd);
    end
    label(1'b0, 0, 8);
    chk("bad frames", 32'h00000000, 32'(kbd.bad_frames));
    apb(1'b0, `BCI_OFS_STAT, 32'h00000000, rd, er);
    chk("status", 32'h00000004, rd);
    results();
  end
endmodule : bci_top_test
